// >>> tsrb_register_bank.sv
`timescale 1ns/100ps
module tsrb_register_bank
  import tsrb_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3c  // Arbitrary identity value.
) (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  clkEn,
  input  tsrb_bus_s                  busIn,
  input  wire logic [1:0]            convDone,
  input  tsrb_temp_s [1:0]           convResult,
  input  wire logic [7:0]            alarmIn,
  output logic [7:0]                 rdData,
  output logic                       rdValid,
  output logic [7:0]                 index,
  output logic                       singleShot,
  output logic                       convAbort,
  output logic [15:0][7:0]           settings,
  output logic                       shutdownSelect,
  output logic                       busTimeoutEnable
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  logic [7:0]       index_r;
  logic [15:0][7:0] settings_r;
  tsrb_temp_s [1:0] temp_r;
  logic [1:0]       lockLo_r;
  logic [1:0]       lockHi_r;
  logic [1:0]       lockLo_nxt;
  logic [1:0]       lockHi_nxt;
  logic [7:0]       rdData_r;
  logic [7:0]       rdData_nxt;
  logic             rdValid_r;
  logic             singleShot_r;
  logic             convAbort_r;
  logic [4:0]       wrHit;
  logic [4:0]       rdHit;
  logic             softRst;

  assign softRst = clkEn & busIn.genReset;
  assign wrHit = tsrb_find(index_r, SLOT_WR_IDX);
  assign rdHit = tsrb_find(index_r, SLOT_RD_IDX);

  ////////////////////////////////////////////////////////////////////////////////
  // Index register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      index_r <= IDX_RESET;
    end else if (clkEn) begin
      if (busIn.genReset) begin
        index_r <= IDX_RESET;
      end else if (busIn.idxLoad) begin
        index_r <= busIn.wrByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Writable settings.
  always_ff @(posedge mclk) begin
    if (srst) begin
      settings_r <= SLOT_RESET;
    end else if (clkEn) begin
      if (busIn.genReset) begin
        settings_r <= SLOT_RESET;
      end else if (busIn.dataLoad && wrHit[4]) begin
        // Only mask bits take the byte; the rest keep their fixed values.
        settings_r[wrHit[3:0]] <= (busIn.wrByte & SLOT_MASK[wrHit[3:0]]) |
                                  (settings_r[wrHit[3:0]] & ~SLOT_MASK[wrHit[3:0]]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion trigger and abort.
  always_ff @(posedge mclk) begin
    if (srst) begin
      singleShot_r <= 1'b0;
      convAbort_r <= 1'b0;
    end else if (clkEn) begin
      singleShot_r <= busIn.dataLoad && !busIn.genReset && (index_r == IDX_TRIGGER);
      convAbort_r <= busIn.genReset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pairing holds.
  always_comb begin
    lockLo_nxt = lockLo_r;
    lockHi_nxt = lockHi_r;
    for (int c = 0; c < 2; c++) begin
      if (busIn.genReset) begin
        lockLo_nxt[c] = 1'b0;
        lockHi_nxt[c] = 1'b0;
      end else if (busIn.readReq && index_r == CH_HI_IDX[c]) begin
        lockLo_nxt[c] = !lockHi_r[c];
        lockHi_nxt[c] = 1'b0;
      end else if (busIn.readReq && index_r == CH_LO_IDX[c]) begin
        lockHi_nxt[c] = !lockLo_r[c];
        lockLo_nxt[c] = 1'b0;
      end else if (busIn.readReq) begin
        lockLo_nxt[c] = 1'b0;
        lockHi_nxt[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lockLo_r <= 2'b00;
      lockHi_r <= 2'b00;
    end else if (clkEn) begin
      lockLo_r <= lockLo_nxt;
      lockHi_r <= lockHi_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Results.
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int c = 0; c < 2; c++) begin
        temp_r[c] <= {TEMP_RESET, 4'h0};
      end
    end else if (clkEn) begin
      for (int c = 0; c < 2; c++) begin
        if (busIn.genReset) begin
          temp_r[c] <= {TEMP_RESET, 4'h0};
        end else if (convDone[c]) begin
          // The hold uses its next value so a read and an update in one cycle still pair.
          if (!lockHi_nxt[c]) begin
            temp_r[c].whole <= convResult[c].whole;
          end
          if (!lockLo_nxt[c]) begin
            temp_r[c].frac <= convResult[c].frac;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.
  always_comb begin
    if (index_r == IDX_LOCAL_HI) begin
      rdData_nxt = temp_r[0].whole;
    end else if (index_r == IDX_LOCAL_LO) begin
      rdData_nxt = {temp_r[0].frac, 4'h0};
    end else if (index_r == IDX_REMOTE_HI) begin
      rdData_nxt = temp_r[1].whole;
    end else if (index_r == IDX_REMOTE_LO) begin
      rdData_nxt = {temp_r[1].frac, 4'h0};
    end else if (index_r == IDX_ALARM) begin
      rdData_nxt = alarmIn;
    end else if (index_r == IDX_MAKER) begin
      rdData_nxt = MAKER_ID;
    end else if (rdHit[4]) begin
      rdData_nxt = settings_r[rdHit[3:0]];
    end else begin
      rdData_nxt = UNMAPPED_READ;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData_r <= UNMAPPED_READ;
      rdValid_r <= 1'b0;
    end else if (clkEn) begin
      rdValid_r <= busIn.readReq && !busIn.genReset;
      if (busIn.readReq) begin
        rdData_r <= rdData_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign index = index_r;
  assign singleShot = singleShot_r;
  assign convAbort = convAbort_r;
  assign settings = settings_r;
  assign shutdownSelect = settings_r[SLOT_SETUP][SHUTDOWN_SELECT_BIT];
  assign busTimeoutEnable = settings_r[SLOT_REPEAT][BUS_TIMEOUT_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  index_load_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.idxLoad && !busIn.genReset |=> index_r == $past(busIn.wrByte))
    else $error("Index did not take the first write byte.");

  index_por_a: assert property (
    @(posedge mclk) disable iff (srst)
    $fell(srst) |-> index_r == IDX_RESET && rdValid_r == 1'b0)
    else $error("Index not zero after reset.");

  result_por_a: assert property (
    @(posedge mclk) disable iff (srst)
    $fell(srst) |-> temp_r[0].whole == TEMP_RESET && temp_r[1].whole == TEMP_RESET)
    else $error("Results not zero after reset.");

  remote_read_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && !busIn.genReset && index_r == IDX_REMOTE_HI
    |=> rdValid_r && rdData_r == $past(temp_r[1].whole))
    else $error("Remote high byte read wrong.");

  local_frac_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && index_r == IDX_LOCAL_LO
    |=> rdData_r[3:0] == 4'h0 && rdData_r[7:4] == $past(temp_r[0].frac))
    else $error("Local low byte layout wrong.");

  low_hold_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && lockLo_r[1] && convDone[1] && !busIn.readReq && !busIn.genReset
    |=> temp_r[1].frac == $past(temp_r[1].frac) && temp_r[1].whole == $past(convResult[1].whole))
    else $error("Held low byte was overwritten.");

  high_hold_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && lockHi_r[1] && convDone[1] && !busIn.readReq && !busIn.genReset
    |=> temp_r[1].whole == $past(temp_r[1].whole)
    && temp_r[1].frac == $past(convResult[1].frac))
    else $error("Held high byte was overwritten.");

  other_read_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && index_r == IDX_ALARM |=> lockLo_r == 2'b00 && lockHi_r == 2'b00)
    else $error("Pairing hold survived another read.");

  result_ro_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && convDone == 2'b00 && !busIn.genReset |=> $stable(temp_r))
    else $error("Result changed without a conversion.");

  read_side_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.dataLoad && !busIn.genReset && index_r == IDX_LUB_RD
    |=> settings_r == $past(settings_r))
    else $error("Write at a read index changed a setting.");

  trigger_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.dataLoad && !busIn.genReset && index_r == IDX_TRIGGER
    |=> singleShot_r && settings_r == $past(settings_r))
    else $error("Trigger write misbehaved.");

  fixed_bits_a: assert property (
    @(posedge mclk) disable iff (srst)
    settings_r[SLOT_REPEAT][0] == 1'b1 && settings_r[SLOT_SETUP][4:3] == 2'b00
    && settings_r[SLOT_SETUP][1:0] == 2'b00)
    else $error("Fixed bit changed.");

  soft_reset_a: assert property (
    @(posedge mclk) disable iff (srst)
    softRst |=> index_r == IDX_RESET && settings_r == SLOT_RESET && convAbort_r
    && lockLo_r == 2'b00)
    else $error("General-call reset incomplete.");

  lo_lock_set_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && !busIn.genReset && index_r == IDX_REMOTE_HI && !lockHi_r[1]
    |=> lockLo_r[1])
    else $error("High byte read did not hold the low byte.");

  hi_lock_set_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && !busIn.genReset && index_r == IDX_REMOTE_LO && !lockLo_r[1]
    |=> lockHi_r[1])
    else $error("Low byte read did not hold the high byte.");

  local_read_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && index_r == IDX_LOCAL_HI |=> rdData_r == $past(temp_r[0].whole))
    else $error("Local high byte read wrong.");

  remote_frac_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && index_r == IDX_REMOTE_LO
    |=> rdData_r == {$past(temp_r[1].frac), 4'h0})
    else $error("Remote low byte layout wrong.");

  read_valid_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && !busIn.genReset |=> rdValid_r)
    else $error("Read gave no valid pulse.");

  valid_pulse_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && !busIn.readReq |=> !rdValid_r)
    else $error("Valid pulse without a read.");

  read_hold_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && !busIn.readReq |=> $stable(rdData_r))
    else $error("Read byte changed without a read.");

  index_hold_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && !busIn.idxLoad && !busIn.genReset |=> $stable(index_r))
    else $error("Index changed without a write.");

  trigger_pulse_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && !(busIn.dataLoad && index_r == IDX_TRIGGER) |=> !singleShot_r)
    else $error("Trigger pulse without a trigger write.");

  abort_pulse_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && !busIn.genReset |=> !convAbort_r)
    else $error("Abort pulse without a general-call reset.");

  clock_freeze_a: assert property (
    @(posedge mclk) disable iff (srst)
    !clkEn |=> $stable(index_r) && $stable(settings_r) && $stable(temp_r))
    else $error("State moved while the clock enable was low.");

  shutdown_rw_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.dataLoad && !busIn.genReset && index_r == IDX_RSHUT
    |=> settings_r[$past(rdHit[3:0])] == $past(busIn.wrByte))
    else $error("Shutdown bound not read back at its own index.");

  offset_low_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.dataLoad && !busIn.genReset && index_r == IDX_ROFS_LO
    |=> settings_r[$past(rdHit[3:0])] == {$past(busIn.wrByte[7:4]), 4'h0})
    else $error("Offset low byte layout wrong.");

  result_write_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.dataLoad && !busIn.genReset && index_r == IDX_LOCAL_HI
    |=> $stable(settings_r) && !singleShot_r)
    else $error("Write to a result register took effect.");

  maker_read_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && busIn.readReq && index_r == IDX_MAKER |=> rdData_r == MAKER_ID)
    else $error("Identity byte read wrong.");

  conv_update_a: assert property (
    @(posedge mclk) disable iff (srst)
    clkEn && convDone[0] && !busIn.readReq && !busIn.genReset && !lockLo_r[0] && !lockHi_r[0]
    |=> temp_r[0] == $past(convResult[0]))
    else $error("Local result not taken from the conversion.");

  soft_result_a: assert property (
    @(posedge mclk) disable iff (srst)
    softRst |=> temp_r[0].whole == TEMP_RESET && temp_r[1].whole == TEMP_RESET
    && lockHi_r == 2'b00 && !singleShot_r && !rdValid_r)
    else $error("General-call reset left results or holds.");

endmodule : tsrb_register_bank

// >>> tsrb_pkg.sv
package tsrb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Index values.
  localparam logic [7:0] IDX_LOCAL_HI = 8'h00;
  localparam logic [7:0] IDX_REMOTE_HI = 8'h01;
  localparam logic [7:0] IDX_ALARM = 8'h02;
  localparam logic [7:0] IDX_SETUP_RD = 8'h03;
  localparam logic [7:0] IDX_RATE_RD = 8'h04;
  localparam logic [7:0] IDX_LUB_RD = 8'h05;
  localparam logic [7:0] IDX_LLB_RD = 8'h06;
  localparam logic [7:0] IDX_RUBH_RD = 8'h07;
  localparam logic [7:0] IDX_RLBH_RD = 8'h08;
  localparam logic [7:0] IDX_SETUP_WR = 8'h09;
  localparam logic [7:0] IDX_RATE_WR = 8'h0a;
  localparam logic [7:0] IDX_LUB_WR = 8'h0b;
  localparam logic [7:0] IDX_LLB_WR = 8'h0c;
  localparam logic [7:0] IDX_RUBH_WR = 8'h0d;
  localparam logic [7:0] IDX_RLBH_WR = 8'h0e;
  localparam logic [7:0] IDX_TRIGGER = 8'h0f;
  localparam logic [7:0] IDX_REMOTE_LO = 8'h10;
  localparam logic [7:0] IDX_ROFS_HI = 8'h11;
  localparam logic [7:0] IDX_ROFS_LO = 8'h12;
  localparam logic [7:0] IDX_RUBL = 8'h13;
  localparam logic [7:0] IDX_RLBL = 8'h14;
  localparam logic [7:0] IDX_LOCAL_LO = 8'h15;
  localparam logic [7:0] IDX_RSHUT = 8'h19;
  localparam logic [7:0] IDX_LSHUT = 8'h20;
  localparam logic [7:0] IDX_HYST = 8'h21;
  localparam logic [7:0] IDX_REPEAT = 8'h22;
  localparam logic [7:0] IDX_IDEAL = 8'h23;
  localparam logic [7:0] IDX_SMOOTH = 8'h24;
  localparam logic [7:0] IDX_MAKER = 8'hfe;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and setting slots.
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int NUM_SLOTS = 16;
  localparam logic [3:0] SLOT_SETUP = 4'h0;
  localparam logic [3:0] SLOT_REPEAT = 4'hd;
  localparam int SHUTDOWN_SELECT_BIT = 6;
  localparam int BUS_TIMEOUT_ENABLE_BIT = 7;

  // Slots run from the filter control at the left down to the setup byte at the right.
  localparam logic [15:0][7:0] SLOT_RD_IDX = {
    IDX_SMOOTH, IDX_IDEAL, IDX_REPEAT, IDX_HYST, IDX_LSHUT, IDX_RSHUT, IDX_RLBL, IDX_RUBL,
    IDX_ROFS_LO, IDX_ROFS_HI, IDX_RLBH_RD, IDX_RUBH_RD, IDX_LLB_RD, IDX_LUB_RD,
    IDX_RATE_RD, IDX_SETUP_RD};
  localparam logic [15:0][7:0] SLOT_WR_IDX = {
    IDX_SMOOTH, IDX_IDEAL, IDX_REPEAT, IDX_HYST, IDX_LSHUT, IDX_RSHUT, IDX_RLBL, IDX_RUBL,
    IDX_ROFS_LO, IDX_ROFS_HI, IDX_RLBH_WR, IDX_RUBH_WR, IDX_LLB_WR, IDX_LUB_WR,
    IDX_RATE_WR, IDX_SETUP_WR};
  localparam logic [15:0][7:0] SLOT_RESET = {
    8'h00, 8'h00, 8'h01, 8'h0a, 8'h55, 8'h6c, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h55, 8'h08, 8'h00};
  localparam logic [15:0][7:0] SLOT_MASK = {
    8'h03, 8'hff, 8'h8e, 8'hff, 8'hff, 8'hff, 8'hf0, 8'hf0,
    8'hf0, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'he4};

  // Channel 0 is the local sensor, channel 1 the remote one.
  localparam logic [1:0][7:0] CH_HI_IDX = {IDX_REMOTE_HI, IDX_LOCAL_HI};
  localparam logic [1:0][7:0] CH_LO_IDX = {IDX_REMOTE_LO, IDX_LOCAL_LO};

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [7:0] whole;
    logic [3:0] frac;
  } tsrb_temp_s;

  typedef struct packed {
    logic       idxLoad;
    logic       dataLoad;
    logic       readReq;
    logic       genReset;
    logic [7:0] wrByte;
  } tsrb_bus_s;

  // Returns a hit flag and the slot whose index matches.
  function automatic logic [4:0] tsrb_find(input logic [7:0] idx,
                                           input logic [15:0][7:0] tbl);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (tbl[i] == idx) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : tsrb_find

endpackage : tsrb_pkg

// >>> tsrb_bus_master.sv
`timescale 1ns/100ps
module tsrb_bus_master
  import tsrb_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid,
  output tsrb_bus_s       busOut
);

  initial busOut = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Kind 0 sets the index, 1 writes data, 2 reads, 3 is the general-call reset.
  task automatic strobe(input logic [1:0] kind, input logic [7:0] val);
    @(negedge mclk);
    busOut.wrByte   = val;
    busOut.idxLoad  = (kind == 2'h0);
    busOut.dataLoad = (kind == 2'h1);
    busOut.readReq  = (kind == 2'h2);
    busOut.genReset = (kind == 2'h3);
    @(negedge mclk);
    busOut.idxLoad  = 1'b0;
    busOut.dataLoad = 1'b0;
    busOut.readReq  = 1'b0;
    busOut.genReset = 1'b0;
    busOut.wrByte   = ~val;
  endtask : strobe

  // A read always sets the index in a write first, then takes the byte.
  task automatic read_at(input logic [7:0] idx, output logic [7:0] val, output logic ok);
    strobe(2'h0, idx);
    strobe(2'h2, ~idx);
    val = rdData;
    ok  = rdValid;
  endtask : read_at

endmodule : tsrb_bus_master

// >>> tb.sv
`timescale 1ns/100ps
module tb
  import tsrb_pkg::*;
();

  logic             mclk = 1'b0;
  logic             srst = 1'b1;
  logic             clkEn = 1'b1;
  logic [1:0]       convDone = 2'h0;
  tsrb_temp_s [1:0] convResult = '0;
  logic [7:0]       alarmIn = 8'h00;
  tsrb_bus_s        busIn;
  logic [7:0]       rdData;
  logic [7:0]       index;
  logic [7:0]       wv;
  logic             rdValid;
  logic             singleShot;
  logic             convAbort;
  logic             shutdownSelect;
  logic             busTimeoutEnable;
  logic [15:0][7:0] settings;
  int               num_errors = 0;
  int               n_tests = 0;
  int               cycles = 0;

  always #20 mclk = ~mclk;

  tsrb_register_bank #(.MAKER_ID(8'h5a)) DUT (
    .mclk(mclk), .srst(srst), .clkEn(clkEn), .busIn(busIn), .convDone(convDone),
    .convResult(convResult), .alarmIn(alarmIn), .rdData(rdData), .rdValid(rdValid),
    .index(index), .singleShot(singleShot), .convAbort(convAbort), .settings(settings),
    .shutdownSelect(shutdownSelect), .busTimeoutEnable(busTimeoutEnable));

  tsrb_bus_master mst (.mclk(mclk), .rdData(rdData), .rdValid(rdValid), .busOut(busIn));

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one byte and counts it.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h got %h", name, exp, got);
    end
  endtask : chk

  // Reads one byte at an index and checks the byte and its valid pulse.
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
    logic [7:0] v;
    logic       ok;
    mst.read_at(idx, v, ok);
    chk(name, exp, v);
    chk("rdValid", 8'h01, {7'h00, ok});
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    mst.strobe(2'h0, idx);
    mst.strobe(2'h1, val);
  endtask : wr

  // Finishes one conversion on a channel.
  task automatic conv(input int ch, input logic [7:0] w, input logic [3:0] f);
    @(negedge mclk);
    convDone[ch]   = 1'b1;
    convResult[ch] = {w, f};
    @(negedge mclk);
    convDone = 2'h0;
  endtask : conv

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    chk("index", IDX_RESET, index);
    for (int i = 0; i < NUM_SLOTS; i++) rd(SLOT_RD_IDX[i], SLOT_RESET[i], "slot");
    rd(IDX_LOCAL_HI, TEMP_RESET, "local hi");
    rd(IDX_LOCAL_LO, TEMP_RESET, "local lo");
    rd(IDX_REMOTE_HI, TEMP_RESET, "remote hi");
    rd(IDX_REMOTE_LO, TEMP_RESET, "remote lo");
    rd(IDX_MAKER, 8'h5a, "maker");
    rd(8'h30, UNMAPPED_READ, "unmapped");
    alarmIn = 8'ha5;
    rd(IDX_ALARM, 8'ha5, "alarm");
    for (int k = 0; k < 2; k++) begin
      wv = (k == 0) ? 8'hff : 8'h00;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        wr(SLOT_WR_IDX[i], wv);
        rd(SLOT_RD_IDX[i], (wv & SLOT_MASK[i]) | (SLOT_RESET[i] & ~SLOT_MASK[i]), "rw");
        chk("settings", (wv & SLOT_MASK[i]) | (SLOT_RESET[i] & ~SLOT_MASK[i]),
            settings[i]);
      end
      chk("shutdownSelect", {7'h00, wv[SHUTDOWN_SELECT_BIT]},
          {7'h00, shutdownSelect});
      chk("busTimeoutEnable", {7'h00, wv[BUS_TIMEOUT_ENABLE_BIT]},
          {7'h00, busTimeoutEnable});
    end
    wr(IDX_LUB_RD, 8'h11);
    rd(IDX_LUB_RD, 8'h00, "read index write");
    mst.strobe(2'h0, 8'h13);
    chk("index", 8'h13, index);
    wr(IDX_TRIGGER, 8'h5a);
    chk("singleShot", 8'h01, {7'h00, singleShot});
    @(negedge mclk);
    chk("singleShot", 8'h00, {7'h00, singleShot});
    conv(0, 8'h0a, 4'h1);
    conv(1, 8'h19, 4'hf);
    wr(IDX_LOCAL_HI, 8'h77);
    rd(IDX_LOCAL_HI, 8'h0a, "local hi");
    rd(IDX_LOCAL_LO, 8'h10, "local lo");
    rd(IDX_REMOTE_HI, 8'h19, "remote hi");
    rd(IDX_REMOTE_LO, 8'hf0, "remote lo");
    rd(IDX_REMOTE_HI, 8'h19, "remote hi");
    conv(1, 8'h20, 4'h3);
    rd(IDX_REMOTE_LO, 8'hf0, "held lo");
    rd(IDX_REMOTE_HI, 8'h20, "new hi");
    rd(IDX_REMOTE_LO, 8'hf0, "lost lo");
    rd(IDX_REMOTE_LO, 8'hf0, "remote lo");
    conv(1, 8'h21, 4'h4);
    rd(IDX_REMOTE_HI, 8'h20, "held hi");
    rd(IDX_REMOTE_LO, 8'h40, "new lo");
    rd(IDX_REMOTE_LO, 8'h40, "remote lo");
    rd(IDX_ALARM, 8'ha5, "alarm");
    conv(1, 8'h22, 4'h5);
    rd(IDX_REMOTE_HI, 8'h22, "free hi");
    rd(IDX_ALARM, 8'ha5, "alarm");
    conv(1, 8'h23, 4'h6);
    rd(IDX_REMOTE_LO, 8'h60, "free lo");
    clkEn = 1'b0;
    mst.strobe(2'h0, IDX_HYST);
    chk("frozen index", IDX_REMOTE_LO, index);
    clkEn = 1'b1;
    wr(IDX_LUB_WR, 8'h60);
    rd(IDX_LUB_RD, 8'h60, "before reset");
    mst.strobe(2'h3, 8'h06);
    chk("convAbort", 8'h01, {7'h00, convAbort});
    chk("index", IDX_RESET, index);
    rd(IDX_LUB_RD, 8'h55, "after reset");
    rd(IDX_REMOTE_HI, TEMP_RESET, "after reset");
    end_of_test();
  end

endmodule : tb
